/* File: design/bit_manipulation_unit.v */
`timescale 1ns/1ps
`include "bit_manip_consts.vh"
// Notes on behaviour
// - set/clear/invert/test take bit number from 3-bit immediate or register low bits
// - bit set forces the selected bit to one, others kept
// - bit clear forces the selected bit to zero, others kept
// - bit invert complements the selected bit, others kept
// - bit test loads zero flag with inverse of bit; operand untouched
// - carry becomes carry AND selected bit
// - carry becomes carry AND inverse of selected bit
// - carry becomes carry OR selected bit
// - carry becomes carry OR inverse of selected bit
// - carry becomes carry XOR selected bit
// - carry becomes carry XOR inverse of selected bit
// - carry takes the selected bit; operand untouched
// - carry takes the inverse of the selected bit; operand untouched
// - selected bit takes carry, other bits kept
// - selected bit takes inverse carry, other bits kept
// - inverted variants accept bit number only from the immediate field
module bit_manipulation_unit (
    input  wire       i_ref_clk,
    input  wire       i_rst,
    input  wire       i_start,
    input  wire [3:0] i_op,
    input  wire       i_src,
    input  wire       i_pos_from_reg,
    input  wire [2:0] i_imm_pos,
    input  wire [7:0] i_pos_reg,
    input  wire [7:0] i_reg_data,
    input  wire [7:0] i_mem_addr,
    input  wire [7:0] i_mem_rdata,
    input  wire       i_mem_ack,
    input  wire [7:0] i_flags,
    output wire       o_busy,
    output wire       o_done,
    output wire       o_error,
    output wire       o_reg_we,
    output wire [7:0] o_reg_wdata,
    output wire       o_mem_req,
    output wire       o_mem_we,
    output wire [7:0] o_mem_addr,
    output wire [7:0] o_mem_wdata,
    output wire       o_flags_we,
    output wire [7:0] o_flags
);
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] op_ff;
    reg       src_ff;
    reg [2:0] pos_ff;
    reg [7:0] byte_ff;
    reg [7:0] flags_ff;
    reg       busy_ff;
    reg       done_ff;
    reg       error_ff;
    reg       reg_we_ff;
    reg [7:0] reg_wdata_ff;
    reg       mem_req_ff;
    reg       mem_we_ff;
    reg [7:0] mem_addr_ff;
    reg [7:0] mem_wdata_ff;
    reg       flags_we_ff;
    reg [7:0] flags_out_ff;
    reg [7:0] wait_cnt_ff;
    reg       abort_ff;

    wire [7:0] res_byte;
    wire       res_carry;
    wire       res_zero;
    wire       wr_byte;
    wire       wr_carry;
    wire       wr_zero;
    wire       legal;
    wire       idle;
    wire       take_op;
    wire       take_bad;
    wire       last_step;
    wire       byte_done;
    wire       mem_wb;
    wire       flag_done;
    wire       wait_over;

    // state codes; only memory operands pass the two read states
    localparam [1:0] ST_IDLE     = 2'h0;
    localparam [1:0] ST_MEM_RD   = 2'h1;
    localparam [1:0] ST_MEM_WAIT = 2'h2;
    localparam [1:0] ST_DONE     = 2'h3;

    // true for operand-inverting variants, which refuse a register bit number
    function is_inverted_op;
        input [3:0] op;
        begin
            is_inverted_op = (op == `OP_CARRY_AND_INV_BIT) ||
                             (op == `OP_CARRY_OR_INV_BIT)  ||
                             (op == `OP_CARRY_XOR_INV_BIT) ||
                             (op == `OP_INV_BIT_TO_CARRY)  ||
                             (op == `OP_INV_CARRY_TO_BIT);
        end
    endfunction

    // merge a new flag byte: only the flag the operation names is touched
    function [7:0] merge_flags;
        input [7:0] old;
        input       wc;
        input       c;
        input       wz;
        input       z;
        reg   [7:0] f;
        begin
            f = old;
            if (wc) begin
                f[`FLAG_C_POS] = c;
            end
            if (wz) begin
                f[`FLAG_Z_POS] = z;
            end
            merge_flags = f;
        end
    endfunction

    wire [2:0] sel_pos = i_pos_from_reg ? i_pos_reg[2:0] : i_imm_pos;
    wire bad_start = is_inverted_op(i_op) && i_pos_from_reg;

    // a start counts in idle only; a start while busy is dropped
    assign idle     = (state_ff == ST_IDLE);
    assign take_op  = idle && i_start && !bad_start;
    assign take_bad = idle && i_start && bad_start;

    // the last step decides which port receives the result
    assign last_step = (state_ff == ST_DONE);
    assign byte_done = last_step && wr_byte && !abort_ff;
    assign mem_wb    = byte_done && (src_ff == `SRC_MEM);
    assign flag_done = last_step && (wr_carry || wr_zero) && !abort_ff;
    assign wait_over = (state_ff == ST_MEM_WAIT) && !i_mem_ack &&
                       (wait_cnt_ff == `MEM_WAIT_MAX);

    bit_op_core u_core (
        .i_op       (op_ff),
        .i_byte     (byte_ff),
        .i_pos      (pos_ff),
        .i_carry    (flags_ff[`FLAG_C_POS]),
        .o_byte     (res_byte),
        .o_carry    (res_carry),
        .o_zero     (res_zero),
        .o_wr_byte  (wr_byte),
        .o_wr_carry (wr_carry),
        .o_wr_zero  (wr_zero),
        .o_legal    (legal)
    );

    // sequencing: register operands finish in one step, memory needs a read
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_op && i_src == `SRC_MEM) begin
                    nxt_state = ST_MEM_RD;
                end else if (take_op) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_MEM_RD: begin
                nxt_state = ST_MEM_WAIT;
            end
            ST_MEM_WAIT: begin
                if (i_mem_ack) begin
                    nxt_state = ST_DONE;
                end else if (wait_over) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // busy spans from the accepted start to the last step
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_ff <= 1'b0;
        end else if (take_op) begin
            busy_ff <= 1'b1;
        end else if (last_step) begin
            busy_ff <= 1'b0;
        end
    end

    // done and error stand one cycle; a refusal answers at once
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            done_ff  <= 1'b0;
            error_ff <= 1'b0;
        end else begin
            done_ff  <= take_bad || last_step;
            error_ff <= take_bad || (last_step && (!legal || abort_ff));
        end
    end

    // operands are frozen at the start so the caller may move on
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            op_ff       <= `OP_NONE;
            src_ff      <= `SRC_REG;
            pos_ff      <= `RST_POS;
            byte_ff     <= `RST_BYTE;
            flags_ff    <= `RST_FLAGS;
            mem_addr_ff <= `RST_ADDR;
        end else if (take_op) begin
            op_ff       <= i_op;
            src_ff      <= i_src;
            pos_ff      <= sel_pos;
            byte_ff     <= i_reg_data;
            flags_ff    <= i_flags;
            mem_addr_ff <= i_mem_addr;
        end else if (state_ff == ST_MEM_WAIT && i_mem_ack) begin
            byte_ff <= i_mem_rdata;
        end
    end

    // a memory that never answers would hold the unit busy for good;
    // after a fixed wait the operation ends with an error and no write
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt_ff <= `RST_WAIT;
            abort_ff    <= 1'b0;
        end else begin
            if (state_ff == ST_MEM_WAIT) begin
                wait_cnt_ff <= wait_cnt_ff + 8'h01;
            end else begin
                wait_cnt_ff <= `RST_WAIT;
            end
            if (take_op) begin
                abort_ff <= 1'b0;
            end else if (wait_over) begin
                abort_ff <= 1'b1;
            end
        end
    end

    // register write-back; the data stays until the next write
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_we_ff    <= 1'b0;
            reg_wdata_ff <= `RST_BYTE;
        end else begin
            reg_we_ff <= byte_done && !mem_wb;
            if (byte_done && !mem_wb) begin
                reg_wdata_ff <= res_byte;
            end
        end
    end

    // memory port: a read pulse, then the full byte goes back even
    // though one bit changed, since memory has no single-bit write
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_req_ff   <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_wdata_ff <= `RST_BYTE;
        end else begin
            mem_req_ff <= (state_ff == ST_MEM_RD) || mem_wb;
            mem_we_ff  <= mem_wb;
            if (mem_wb) begin
                mem_wdata_ff <= res_byte;
            end
        end
    end

    // flag port: the untouched flags go back as they came in
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_we_ff  <= 1'b0;
            flags_out_ff <= `RST_FLAGS;
        end else begin
            flags_we_ff <= flag_done;
            if (flag_done) begin
                flags_out_ff <= merge_flags(flags_ff, wr_carry,
                    res_carry, wr_zero, res_zero);
            end
        end
    end

    assign o_busy      = busy_ff;
    assign o_done      = done_ff;
    assign o_error     = error_ff;
    assign o_reg_we    = reg_we_ff;
    assign o_reg_wdata = reg_wdata_ff;
    assign o_mem_req   = mem_req_ff;
    assign o_mem_we    = mem_we_ff;
    assign o_mem_addr  = mem_addr_ff;
    assign o_mem_wdata = mem_wdata_ff;
    assign o_flags_we  = flags_we_ff;
    assign o_flags     = flags_out_ff;
endmodule // bit_manipulation_unit

/* File: design/bit_op_core.v */
`timescale 1ns/1ps
`include "bit_manip_consts.vh"
// combinational bit/flag arithmetic for one operation
module bit_op_core (
    input  wire [3:0] i_op,
    input  wire [7:0] i_byte,
    input  wire [2:0] i_pos,
    input  wire       i_carry,
    output reg  [7:0] o_byte,
    output reg        o_carry,
    output reg        o_zero,
    output reg        o_wr_byte,
    output reg        o_wr_carry,
    output reg        o_wr_zero,
    output reg        o_legal
);
    reg [7:0] mask;
    reg       bit_val;

    // one-hot mask of the selected bit, and that bit's value
    always @* begin
        mask    = 8'h01 << i_pos;
        bit_val = i_byte[i_pos];
        o_byte     = i_byte;
        o_carry    = i_carry;
        o_zero     = 1'b0;
        o_wr_byte  = 1'b0;
        o_wr_carry = 1'b0;
        o_wr_zero  = 1'b0;
        o_legal    = 1'b1;
        case (i_op)
            `OP_BIT_SET: begin
                o_byte = i_byte | mask;
                o_wr_byte = 1'b1;
            end
            `OP_BIT_CLEAR: begin
                o_byte = i_byte & ~mask;
                o_wr_byte = 1'b1;
            end
            `OP_BIT_INVERT: begin
                o_byte = i_byte ^ mask;
                o_wr_byte = 1'b1;
            end
            `OP_BIT_TEST: begin
                o_zero = ~bit_val;
                o_wr_zero = 1'b1;
            end
            `OP_CARRY_AND_BIT: begin
                o_carry = i_carry & bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_AND_INV_BIT: begin
                o_carry = i_carry & ~bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_OR_BIT: begin
                o_carry = i_carry | bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_OR_INV_BIT: begin
                o_carry = i_carry | ~bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_XOR_BIT: begin
                o_carry = i_carry ^ bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_XOR_INV_BIT: begin
                o_carry = i_carry ^ ~bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_BIT_TO_CARRY: begin
                o_carry = bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_INV_BIT_TO_CARRY: begin
                o_carry = ~bit_val;
                o_wr_carry = 1'b1;
            end
            `OP_CARRY_TO_BIT: begin
                o_byte = i_carry ? (i_byte | mask) : (i_byte & ~mask);
                o_wr_byte = 1'b1;
            end
            `OP_INV_CARRY_TO_BIT: begin
                o_byte = i_carry ? (i_byte & ~mask) : (i_byte | mask);
                o_wr_byte = 1'b1;
            end
            default: begin
                o_legal = 1'b0;
            end
        endcase
    end
endmodule // bit_op_core

/* File: shared/bit_manip_consts.vh */
`ifndef BIT_MANIP_CONSTS_VH
`define BIT_MANIP_CONSTS_VH
// operation codes on i_op (4 bits)
`define OP_NONE              4'h0
`define OP_BIT_SET           4'h1
`define OP_BIT_CLEAR         4'h2
`define OP_BIT_INVERT        4'h3
`define OP_BIT_TEST          4'h4
`define OP_CARRY_AND_BIT     4'h5
`define OP_CARRY_AND_INV_BIT 4'h6
`define OP_CARRY_OR_BIT      4'h7
`define OP_CARRY_OR_INV_BIT  4'h8
`define OP_CARRY_XOR_BIT     4'h9
`define OP_CARRY_XOR_INV_BIT 4'ha
`define OP_BIT_TO_CARRY      4'hb
`define OP_INV_BIT_TO_CARRY  4'hc
`define OP_CARRY_TO_BIT      4'hd
`define OP_INV_CARRY_TO_BIT  4'he
// operand sources
`define SRC_REG              1'b0
`define SRC_MEM              1'b1
// flag byte layout
`define FLAG_C_POS           0
`define FLAG_Z_POS           2
// reset values
`define RST_BYTE             8'h00
`define RST_FLAGS            8'h00
`define RST_POS              3'h0
`define RST_ADDR             8'h00
`define RST_WAIT             8'h00
// cycles a memory read may wait for its answer before it is given up
`define MEM_WAIT_MAX         8'h10
`endif

/* File: testbench/bit_manipulation_unit_checker.sv */
`timescale 1ns/1ps
// port-level timing and side-effect checks for the bit unit
module bit_manipulation_unit_checker (
    input wire       i_ref_clk,
    input wire       i_rst,
    input wire       i_start,
    input wire [3:0] i_op,
    input wire       i_src,
    input wire       i_pos_from_reg,
    input wire       i_mem_ack,
    input wire [7:0] i_flags,
    input wire       o_busy,
    input wire       o_done,
    input wire       o_error,
    input wire       o_reg_we,
    input wire       o_mem_req,
    input wire       o_mem_we,
    input wire       o_flags_we,
    input wire [7:0] o_flags
);
    reg  [7:0] flg_ff;
    // a start is checked only while idle and outside the done cycle; the unit also takes one in the done cycle
    wire acc = i_start && !o_busy && !o_done;
    wire inv = i_op inside {4'h6, 4'h8, 4'ha, 4'hc, 4'he};
    wire ok  = i_op != 4'h0 && i_op != 4'hf && !(inv && i_pos_from_reg);
    // flags at the start; untouched bits are compared against them
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            flg_ff <= 8'h00;
        else if (acc)
            flg_ff <= i_flags;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence reg_walk;
        ##1 o_busy ##1 (o_done && !o_busy);
    endsequence
    sequence mem_read;
        ##2 (o_mem_req && !o_mem_we);
    endsequence
    reg_walk_a: assert property (acc && ok && !i_src |-> reg_walk)
        else $error("register op late");
    refuse_inv_a: assert property (acc && inv && i_pos_from_reg
        |=> o_error && !o_reg_we && !o_flags_we) else $error("refused op");
    mem_read_a: assert property (acc && ok && i_src |-> mem_read)
        else $error("no memory read");
    ack_done_a: assert property (o_busy && i_mem_ack |-> ##2 o_done)
        else $error("no done after ack");
    mem_wb_a: assert property (o_mem_we |-> o_done && !o_flags_we)
        else $error("bad memory write");
    flags_kept_a: assert property (o_flags_we
        |-> (o_flags & 8'hfa) == (flg_ff & 8'hfa)) else $error("flags moved");
    test_keeps_a: assert property (o_flags_we |-> !o_reg_we && !o_mem_we)
        else $error("operand written");
    error_pair_a: assert property (o_error |-> o_done)
        else $error("error without done");
endmodule // bit_manipulation_unit_checker

bind bit_manipulation_unit bit_manipulation_unit_checker checker_inst (
    .i_ref_clk, .i_rst, .i_start, .i_op, .i_src, .i_pos_from_reg,
    .i_mem_ack, .i_flags, .o_busy, .o_done, .o_error, .o_reg_we,
    .o_mem_req, .o_mem_we, .o_flags_we, .o_flags
);

/* File: testbench/bit_manipulation_unit_test.sv */
`timescale 1ns/1ps
`include "bit_manip_consts.vh"
module bit_manipulation_unit_test;
    reg        i_ref_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0;
    reg        i_src = 1'b0, i_pos_from_reg = 1'b0;
    reg  [3:0] i_op = 4'h0, lag = 4'h0;
    reg  [2:0] i_imm_pos = 3'h0;
    reg  [7:0] i_pos_reg = 8'h00, i_reg_data = 8'h00, i_flags = 8'h00;
    wire       i_mem_ack, o_busy, o_done, o_error, o_reg_we, o_mem_req;
    wire       o_mem_we, o_flags_we;
    wire [7:0] i_mem_rdata, o_reg_wdata, o_mem_addr, o_mem_wdata, o_flags;
    reg        w_reg, w_flg, w_mem, err;
    reg  [7:0] d_reg, d_flg;
    integer    bad_count = 0, compares = 0;
    bit_manipulation_unit bit_manipulation_unit_inst (
        .i_ref_clk, .i_rst, .i_start, .i_op, .i_src, .i_pos_from_reg,
        .i_imm_pos, .i_pos_reg, .i_reg_data, .i_mem_addr(8'h3c),
        .i_mem_rdata, .i_mem_ack, .i_flags, .o_busy, .o_done, .o_error,
        .o_reg_we, .o_reg_wdata, .o_mem_req, .o_mem_we, .o_mem_addr,
        .o_mem_wdata, .o_flags_we, .o_flags);
    mem_model mem_model_inst (.i_ref_clk, .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_lag(lag), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    always #4 i_ref_clk = ~i_ref_clk;
    // watchdog: the whole run needs a small part of this
    initial begin
        #200000;
        bad_count = bad_count + 1;
        results;
    end
    task chk(input [63:0] nm, input [7:0] e, input [7:0] s);
        begin
            compares = compares + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // one op; the unused bit source points at another bit
    task run(input [3:0] op, input src, input pfr, input [2:0] p,
             input [7:0] d, input [7:0] f);
        integer k;
        begin
            i_op = op;
            i_src = src;
            i_pos_from_reg = pfr;
            i_imm_pos = pfr ? ~p : p;
            i_pos_reg = {5'h15, pfr ? p : ~p};
            i_reg_data = d;
            i_flags = f;
            i_start = 1'b1;
            @(negedge i_ref_clk);
            i_start = 1'b0;
            for (k = 0; k < 30 && o_done !== 1'b1; k = k + 1)
                @(negedge i_ref_clk);
            chk("done", 8'h01, {7'h00, o_done});
            {w_reg, w_flg, w_mem, err} = {o_reg_we, o_flags_we,
                                          o_mem_we, o_error};
            d_reg = o_reg_wdata;
            d_flg = o_flags;
            @(negedge i_ref_clk); // gap: no start in the done cycle
        end
    endtask
    task t_modify;
        integer p;
        reg [7:0] b;
        begin
            for (p = 0; p < 16; p = p + 1) begin
                b = 8'h01 << p[2:0];
                run(`OP_BIT_SET, 1'b0, p[3], p[2:0], 8'h00, 8'h00);
                chk("set", b, d_reg);
                run(`OP_BIT_CLEAR, 1'b0, p[3], p[2:0], 8'hff, 8'h00);
                chk("clear", ~b, d_reg);
                run(`OP_BIT_INVERT, 1'b0, p[3], p[2:0], 8'ha5, 8'h00);
                chk("invert", 8'ha5 ^ b, d_reg);
                run(`OP_CARRY_TO_BIT, 1'b0, p[3], p[2:0], 8'h5a, 8'h01);
                chk("store", 8'h5a | b, d_reg);
                run(`OP_INV_CARRY_TO_BIT, 1'b0, 1'b0, p[2:0], 8'h5a, 8'h01);
                chk("istore", 8'h5a & ~b, d_reg);
            end
            $display("modify test done");
        end
    endtask
    // flag ops over every carry and bit pair, other flags preset
    task t_flag_ops;
        integer n;
        reg [3:0] op;
        reg       c, b, e;
        begin
            for (n = 0; n < 36; n = n + 1) begin
                op = 4'h4 + n[5:2];
                c = n[0];
                b = n[1];
                case (op)
                    `OP_CARRY_AND_BIT:     e = c & b;
                    `OP_CARRY_AND_INV_BIT: e = c & ~b;
                    `OP_CARRY_OR_BIT:      e = c | b;
                    `OP_CARRY_OR_INV_BIT:  e = c | ~b;
                    `OP_CARRY_XOR_BIT:     e = c ^ b;
                    `OP_CARRY_XOR_INV_BIT: e = c ^ ~b;
                    `OP_BIT_TO_CARRY:      e = b;
                    default:               e = ~b;
                endcase
                run(op, 1'b0, c & (op[0] | op == `OP_BIT_TEST), 3'h5,
                    b ? 8'h20 : 8'hdf, {7'h6d, c});
                chk("flags", op == `OP_BIT_TEST ? {5'h1b, e, 1'b1, c}
                    : {7'h6d, e}, d_flg);
                chk("no_wr", 8'h02, {6'h00, w_flg, w_reg | err});
            end
            $display("flag test done");
        end
    endtask
    task t_mem;
        begin
            mem_model_inst.mem[8'h3c] = 8'h81;
            lag = 4'h5;
            run(`OP_BIT_SET, 1'b1, 1'b0, 3'h4, 8'h00, 8'hda);
            chk("mem_set", 8'h91, mem_model_inst.mem[8'h3c]);
            lag = 4'h0;
            run(`OP_BIT_INVERT, 1'b1, 1'b1, 3'h0, 8'h00, 8'hda);
            chk("mem_inv", 8'h90, mem_model_inst.mem[8'h3c]);
            run(`OP_INV_BIT_TO_CARRY, 1'b1, 1'b0, 3'h7, 8'h00, 8'hdb);
            chk("mem_ild", 8'hda, d_flg);
            chk("mem_kept", 8'h90, mem_model_inst.mem[8'h3c]);
            lag = 4'hf;
            run(`OP_BIT_CLEAR, 1'b1, 1'b0, 3'h4, 8'h00, 8'hda);
            chk("mem_mute", 8'h08, {4'h0, err, w_reg, w_flg, w_mem});
            chk("mem_left", 8'h90, mem_model_inst.mem[8'h3c]);
            lag = 4'h0;
            $display("memory test done");
        end
    endtask
    task t_refuse;
        integer n;
        reg [3:0] op;
        begin
            for (n = 0; n < 7; n = n + 1) begin
                op = (n < 5) ? 4'h6 + {n[2:0], 1'b0} : {4{n[0]}};
                run(op, n[0], 1'b1, 3'h2, 8'h55, 8'hdb);
                chk("refused", 8'h08, {4'h0, err, w_reg, w_flg, w_mem});
            end
            $display("refusal test done");
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // six cycles of reset, then the tests in turn
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_rst = 1'b0;
        @(negedge i_ref_clk);
        t_modify;
        t_flag_ops;
        t_mem;
        t_refuse;
        results;
    end
endmodule // bit_manipulation_unit_test

/* File: testbench/mem_model.sv */
`timescale 1ns/1ps
// byte memory on the far side; read answer after a chosen lag
module mem_model (
    input  wire       i_ref_clk,
    input  wire       i_req,
    input  wire       i_we,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire [3:0] i_lag,
    output reg        o_ack = 1'b0,
    output reg  [7:0] o_rdata = 8'h00
);
    reg [7:0] mem [0:255];
    reg [7:0] adr;
    // whole byte comes back in one write
    always @(posedge i_ref_clk) begin
        if (i_req && i_we)
            mem[i_addr] <= i_wdata;
    end
    // released bus shows the inverse so stale data cannot pass;
    // a lag of all ones plays a memory that never answers
    always @(posedge i_ref_clk) begin
        if (i_req && !i_we && i_lag != 4'hf) begin
            adr = i_addr;
            repeat (i_lag) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            o_ack = 1'b1;
            o_rdata = mem[adr];
            @(negedge i_ref_clk);
            o_ack = 1'b0;
            o_rdata = ~mem[adr];
        end
    end
endmodule // mem_model
